//--- lad_adc_model.sv
// Converter model: delivers conversions on the converter port
`timescale 1ns/1ns
module lad_adc_model (
    // Clock
    input  wire logic        clk_i,
    // Converter port
    output logic             done_o,
    output logic [2:0]       ch_o,
    output logic [11:0]      data_o
);
    initial begin
        done_o = 1'b0;
        ch_o   = 3'h0;
        data_o = 12'h000;
    end

    // ****
    // One conversion
    // ****
    // Data inverted after the pulse so a late sample never looks valid
    task automatic convert(input logic [2:0] ch, input logic [11:0] d);
        @(posedge clk_i);
        #2;
        done_o = 1'b1;
        ch_o   = ch;
        data_o = d;
        @(posedge clk_i);
        #2;
        done_o = 1'b0;
        data_o = ~d;
    endtask
endmodule

//--- lad_pad_filter.sv
// Glitch filter for the I2C and earbud communication pads
`timescale 1ns/1ns
module lad_pad_filter #(
    parameter int PADS   = 4,
    parameter int CYCLES = lad_pkg::FILTER_CYCLES
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    // Control
    input  wire logic            enable_i,
    // Pads
    input  wire logic [PADS-1:0] raw_i,
    output logic      [PADS-1:0] clean_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    genvar g;
    generate
        for (g = 0; g < PADS; g++) begin : g_pad
            logic [CW-1:0] stable_cnt;

            // A level must hold CYCLES samples to pass; a level that returns on the sample after the output flips passes at once
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stable_cnt <= '0;
                end else if (raw_i[g] == clean_o[g]) begin
                    stable_cnt <= '0;
                end else if (stable_cnt != LAST) begin
                    stable_cnt <= stable_cnt + CW'(1);
                end
            end

            // Idle pads rest high, so reset to one
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    clean_o[g] <= 1'b1;
                end else if (!enable_i) begin
                    clean_o[g] <= raw_i[g];
                end else if (raw_i[g] != clean_o[g] &&
                             stable_cnt == LAST) begin
                    clean_o[g] <= raw_i[g];
                end
            end
        end
    endgenerate
endmodule

//--- lad_pkg.sv
// Package: register map, field layout and timing for the LED/ADC/debug bank
package lad_pkg;

    // ********************************************************************
    // Register addresses
    // ********************************************************************
    localparam logic [4:0] LED_CONTROL_ADDR = 5'h0D;
    localparam logic [4:0] ADC_RESULT_ADDR  = 5'h0E;
    localparam logic [4:0] DEBUG_CTRL_ADDR  = 5'h0F;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int LED_MANUAL_LSB    = 10;
    localparam int LED_MANUAL_MSB    = 13;
    localparam int LED_COUNT_LSB     = 1;
    localparam int LED_COUNT_MSB     = 2;
    localparam int LED_OVERRIDE_BIT  = 0;
    localparam int ADC_RESULT_LSB    = 4;
    localparam int ADC_RESULT_MSB    = 15;
    localparam int ANALOG_CHANNEL_SELECT_LSB     = 1;
    localparam int ANALOG_CHANNEL_SELECT_MSB     = 3;
    localparam int DEBUG_FILTER_BIT  = 15;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [3:0]  MANUAL_RESET   = 4'h0;
    localparam logic [1:0]  COUNT_RESET    = 2'h0;
    localparam logic        OVERRIDE_RESET = 1'b0;
    localparam logic [11:0] RESULT_RESET   = 12'h000;
    localparam logic [2:0]  CHSEL_RESET    = 3'h0;
    localparam logic        FILTER_RESET   = 1'b1;

    // ********************************************************************
    // Lamp count and analog channel codes
    // ********************************************************************
    localparam logic [1:0] LAMPS_TWO   = 2'h0;
    localparam logic [1:0] LAMPS_THREE = 2'h1;
    localparam logic [1:0] LAMPS_ONE   = 2'h2;
    localparam logic [1:0] LAMPS_FOUR  = 2'h3;

    localparam logic [2:0] CH_BATTERY        = 3'h0;
    localparam logic [2:0] CH_CHARGER_INPUT  = 3'h1;
    localparam logic [2:0] CH_LEFT_BUD_SENSE = 3'h2;
    localparam logic [2:0] CH_RIGHT_BUD_SENSE = 3'h3;
    localparam logic [2:0] CH_SHARED_LINE    = 3'h4;
    localparam logic [2:0] CH_CHARGE_CURRENT = 3'h5;
    localparam logic [2:0] CH_INPUT_CURRENT  = 3'h6;
    localparam logic [2:0] CH_ANALOG_GROUND  = 3'h7;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int FILTER_MIN_NS = 150;
    localparam int FILTER_CYCLES =
        (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } lad_reg_req_t;

    typedef struct packed {
        logic        done;
        logic [2:0]  ch;
        logic [11:0] data;
    } lad_adc_sample_t;

endpackage

//--- lad_regs.sv
// LED control, ADC result/channel and debug filter register bank
// How it works
// - With the override bit set the lamps follow the host's level bits.
// - With override clear (reset) the hardware display drives the lamps.
// - Bits 13:10 are host levels for lamps four to one, 1 on, reset 0.
// - Bits 2:1 pick lamp count: 00 two, 01 three, 10 one, 11 four.
// - The ADC word carries a read-only 12-bit result in bits 15:4.
// - ADC bits 3:1 select one of eight analog channels.
// - Debug bit 15 enables the pad glitch filter, reset 1; 0 bypasses it.
`timescale 1ns/1ns
module lad_regs #(
    parameter int PADS = 4
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    // Register access
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic [4:0]              reg_addr_i,
    input  wire logic [15:0]             reg_wdata_i,
    output logic      [15:0]             reg_rdata_o,
    output logic                         reg_rvalid_o,
    // Lamps
    input  wire logic [3:0]              hw_led_i,
    output logic      [3:0]              led_o,
    output logic      [1:0]              lamp_count_o,
    // Converter
    input  wire logic                    adc_done_i,
    input  wire logic [2:0]              adc_ch_i,
    input  wire logic [11:0]             adc_data_i,
    output logic      [2:0]              analog_channel_select_o,
    // Pads
    input  wire logic [PADS-1:0]         pad_raw_i,
    output logic      [PADS-1:0]         pad_clean_o,
    output logic                         filter_on_o
);
    // ********************************************************************
    // Reset release
    // ********************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ********************************************************************
    // Carriers and state
    // ********************************************************************
    lad_pkg::lad_reg_req_t    req;
    lad_pkg::lad_adc_sample_t smp;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                   wdata: reg_wdata_i};
    assign smp = '{done: adc_done_i, ch: adc_ch_i, data: adc_data_i};

    logic [3:0]  manual_level;
    logic [1:0]  lamp_count_select;
    logic        host_lamp_override;
    logic [11:0] conversion_result;
    logic [2:0]  analog_channel_select;
    logic        pad_glitch_filter_on;

    function automatic logic hit(input lad_pkg::lad_reg_req_t r,
                                 input logic [4:0] a);
        hit = r.addr == a;
    endfunction

    logic wr_led;
    logic wr_adc;
    logic wr_dbg;

    assign wr_led = req.wr && hit(req, lad_pkg::LED_CONTROL_ADDR);
    assign wr_adc = req.wr && hit(req, lad_pkg::ADC_RESULT_ADDR);
    assign wr_dbg = req.wr && hit(req, lad_pkg::DEBUG_CTRL_ADDR);

    // ********************************************************************
    // LED control register
    // ********************************************************************
    // Reserved bits are dropped on write and read back as zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            manual_level       <= lad_pkg::MANUAL_RESET;
            lamp_count_select  <= lad_pkg::COUNT_RESET;
            host_lamp_override <= lad_pkg::OVERRIDE_RESET;
        end else if (wr_led) begin
            manual_level <= req.wdata[lad_pkg::LED_MANUAL_MSB:
                                      lad_pkg::LED_MANUAL_LSB];
            lamp_count_select <= req.wdata[lad_pkg::LED_COUNT_MSB:
                                           lad_pkg::LED_COUNT_LSB];
            host_lamp_override <= req.wdata[lad_pkg::LED_OVERRIDE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            led_o        <= 4'h0;
            lamp_count_o <= lad_pkg::COUNT_RESET;
        end else begin
            led_o        <= host_lamp_override ? manual_level
                                               : hw_led_i;
            lamp_count_o <= lamp_count_select;
        end
    end

    // ********************************************************************
    // ADC register
    // ********************************************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_channel_select <= lad_pkg::CHSEL_RESET;
        end else if (wr_adc) begin
            analog_channel_select <= req.wdata[lad_pkg::ANALOG_CHANNEL_SELECT_MSB:
                                               lad_pkg::ANALOG_CHANNEL_SELECT_LSB];
        end
    end

    // Results for a channel no longer selected are stale and ignored
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conversion_result <= lad_pkg::RESULT_RESET;
        end else if (smp.done && smp.ch == analog_channel_select) begin
            conversion_result <= smp.data;
        end
    end

    assign analog_channel_select_o = analog_channel_select;

    // ********************************************************************
    // Debug register and pad filter
    // ********************************************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pad_glitch_filter_on <= lad_pkg::FILTER_RESET;
        end else if (wr_dbg) begin
            pad_glitch_filter_on <= req.wdata[lad_pkg::DEBUG_FILTER_BIT];
        end
    end

    assign filter_on_o = pad_glitch_filter_on;

    lad_pad_filter #(
        .PADS   (PADS),
        .CYCLES (lad_pkg::FILTER_CYCLES)
    ) u_filter (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .enable_i (pad_glitch_filter_on),
        .raw_i    (pad_raw_i),
        .clean_o  (pad_clean_o)
    );

    // ********************************************************************
    // Read path
    // ********************************************************************
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (hit(req, lad_pkg::LED_CONTROL_ADDR)) begin
            next_rdata[lad_pkg::LED_MANUAL_MSB:lad_pkg::LED_MANUAL_LSB] =
                manual_level;
            next_rdata[lad_pkg::LED_COUNT_MSB:lad_pkg::LED_COUNT_LSB] =
                lamp_count_select;
            next_rdata[lad_pkg::LED_OVERRIDE_BIT] = host_lamp_override;
        end else if (hit(req, lad_pkg::ADC_RESULT_ADDR)) begin
            next_rdata[lad_pkg::ADC_RESULT_MSB:lad_pkg::ADC_RESULT_LSB] =
                conversion_result;
            next_rdata[lad_pkg::ANALOG_CHANNEL_SELECT_MSB:lad_pkg::ANALOG_CHANNEL_SELECT_LSB] =
                analog_channel_select;
        end else if (hit(req, lad_pkg::DEBUG_CTRL_ADDR)) begin
            next_rdata[lad_pkg::DEBUG_FILTER_BIT] = pad_glitch_filter_on;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= req.rd;
            if (req.rd) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    chk_led_host_drive: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        host_lamp_override |=> led_o == $past(manual_level))
        else $error("lamps do not follow host levels");

    chk_led_hw_drive: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !host_lamp_override |=> led_o == $past(hw_led_i))
        else $error("lamps do not follow hardware display");

    chk_manual_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_led ##1 host_lamp_override |=>
            led_o == $past(reg_wdata_i[13:10], 2))
        else $error("manual level write not seen on lamps");

    chk_count_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_led |=> ##1 lamp_count_o == $past(reg_wdata_i[2:1], 2))
        else $error("lamp count not taken");

    chk_result_read: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        reg_rd_i && reg_addr_i == lad_pkg::ADC_RESULT_ADDR |=>
            reg_rvalid_o && reg_rdata_o[0] == 1'b0 &&
            reg_rdata_o[15:4] == $past(conversion_result))
        else $error("adc result read wrong");

    chk_chsel_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wr_adc |=> analog_channel_select_o == $past(reg_wdata_i[3:1]))
        else $error("channel select not taken");

    chk_filter_bypass: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !filter_on_o |=> pad_clean_o == $past(pad_raw_i))
        else $error("bypassed filter does not pass pads");

    chk_result_match: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        adc_done_i && adc_ch_i == analog_channel_select_o |=>
            conversion_result == $past(adc_data_i))
        else $error("selected channel result not stored");

    chk_result_stale: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !(adc_done_i && adc_ch_i == analog_channel_select_o) |=>
            $stable(conversion_result))
        else $error("result changed without matching conversion");
endmodule

//--- lad_regs_test.sv
// Self-checking bench for the lamp, converter and debug register bank
`timescale 1ns/1ns
module lad_regs_test;
    localparam logic [4:0] A_LED = lad_pkg::LED_CONTROL_ADDR;
    localparam logic [4:0] A_ADC = lad_pkg::ADC_RESULT_ADDR;
    localparam logic [4:0] A_DBG = lad_pkg::DEBUG_CTRL_ADDR;

    logic        clk_i;
    logic        nrst_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [4:0]  reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic [15:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic [3:0]  hw_led_i;
    logic [3:0]  led_o;
    logic [1:0]  lamp_count_o;
    logic        adc_done_i;
    logic [2:0]  adc_ch_i;
    logic [11:0] adc_data_i;
    logic [2:0]  analog_channel_select_o;
    logic [3:0]  pad_raw_i;
    logic [3:0]  pad_clean_o;
    logic        filter_on_o;
    int          num_errors;
    int          check_count;
    int          cycles;
    logic [3:0]  man;
    logic [11:0] dat;

    lad_regs #(.PADS(4)) i_lad_regs (
        .clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .hw_led_i, .led_o,
        .lamp_count_o, .adc_done_i, .adc_ch_i, .adc_data_i,
        .analog_channel_select_o, .pad_raw_i, .pad_clean_o, .filter_on_o
    );

    lad_adc_model i_lad_adc_model (
        .clk_i  (clk_i),
        .done_o (adc_done_i),
        .ch_o   (adc_ch_i),
        .data_o (adc_data_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Tests need about 140 cycles; the cap catches a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            final_report();
        end
    end

    // ****
    // Expectations and checks
    // ****
    function automatic logic [15:0] led_word(logic [3:0] m, logic [1:0] c,
                                             logic o);
        return {2'h0, m, 7'h00, c, o};
    endfunction

    function automatic logic [15:0] adc_word(logic [11:0] d, logic [2:0] c);
        return {d, c, 1'b0};
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        chk_word({12'h000, got}, {12'h000, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #2;
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        @(posedge clk_i);
        #2;
        reg_wr_i = 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        #2;
        reg_rd_i   = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i);
        #2;
        reg_rd_i = 1'b0;
        chk_pin({3'h0, reg_rvalid_o}, 4'h1);
        chk_word(reg_rdata_o, exp);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        nrst_i      = 1'b0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 5'h00;
        reg_wdata_i = 16'h0000;
        hw_led_i    = 4'h0;
        pad_raw_i   = 4'hF;
        num_errors  = 0;
        check_count = 0;
        cycles      = 0;
        void'($urandom(80));
        repeat (8) @(posedge clk_i);
        #2;
        nrst_i = 1'b1;
        tick(3);

        rd_chk(A_LED, 16'h0000);
        rd_chk(A_ADC, 16'h0000);
        rd_chk(A_DBG, 16'h8000);
        rd_chk(5'h1A, 16'h0000);
        chk_pin({3'h0, filter_on_o}, 4'h1);
        $display("test reset_values done");

        // Override off for codes 0..3, on for 4..7; reserved bits kept 0
        for (int i = 0; i < 8; i++) begin
            man      = 4'($urandom);
            hw_led_i = 4'($urandom);
            wr(A_LED, led_word(man, 2'(i), i[2]));
            tick(1);
            chk_pin(led_o, i[2] ? man : hw_led_i);
            chk_pin({2'h0, lamp_count_o}, 4'(i[1:0]));
            rd_chk(A_LED, led_word(man, 2'(i), i[2]));
        end
        $display("test lamps done");

        // Result bits written at random must not stick
        for (int c = 0; c < 8; c++) begin
            dat = 12'($urandom);
            wr(A_ADC, {12'($urandom), 3'(c), 1'b0});
            chk_pin({1'b0, analog_channel_select_o}, 4'(c));
            i_lad_adc_model.convert(3'(c), dat);
            i_lad_adc_model.convert(3'(c + 1), ~dat);
            rd_chk(A_ADC, adc_word(dat, 3'(c)));
        end
        $display("test converter done");

        wr(A_DBG, 16'h0000);
        chk_pin({3'h0, filter_on_o}, 4'h0);
        pad_raw_i = 4'h5;
        tick(1);
        chk_pin(pad_clean_o, 4'h5);
        wr(A_DBG, 16'h8000);
        rd_chk(A_DBG, 16'h8000);
        // Two-sample glitch is shorter than the filter window
        pad_raw_i = 4'hA;
        tick(2);
        pad_raw_i = 4'h5;
        tick(4);
        chk_pin(pad_clean_o, 4'h5);
        // Third matching sample lets the new level through, not earlier
        pad_raw_i = 4'hA;
        tick(2);
        chk_pin(pad_clean_o, 4'h5);
        tick(1);
        chk_pin(pad_clean_o, 4'hA);
        tick(2);
        chk_pin(pad_clean_o, 4'hA);
        $display("test pad_filter done");
        final_report();
    end
endmodule
